// ===== logic/spcc_top.v
// Top of the serial port configuration checker, two ports
`timescale 1ns/100ps
`include "spcc_regs.vh"

module spcc_top (
	input  wire                                core_clk,                // System clock, 25 MHz
	input  wire                                rst,                     // Asynchronous reset, high
	input  wire [`SPCC_PORTS*`SPCC_CW-1:0]     cfg_term_type,           // Per port termination type
	input  wire [`SPCC_PORTS*`SPCC_BW-1:0]     cfg_baud,                // Per port baud, bit/s
	input  wire [`SPCC_PORTS*`SPCC_CW-1:0]     cfg_parity,              // Per port parity code
	input  wire [`SPCC_PORTS*`SPCC_CW-1:0]     cfg_data_bits,           // Per port data bits
	input  wire [`SPCC_PORTS*`SPCC_CW-1:0]     cfg_stop_bits,           // Per port stop bits
	input  wire [`SPCC_PORTS*`SPCC_CW-1:0]     cfg_handshake,           // Per port handshake code
	input  wire [`SPCC_PORTS*`SPCC_CW-1:0]     cfg_term_count,          // Per port string length
	input  wire [`SPCC_PORTS*`SPCC_CW-1:0]     cfg_packet_len,          // Per port packet length
	input  wire [`SPCC_PORTS*`SPCC_CW-1:0]     cfg_rx_timeout,          // Per port message timeout
	input  wire [`SPCC_PORTS*`SPCC_CW-1:0]     cfg_gap,                 // Per port char gap
	input  wire [`SPCC_PORTS*`SPCC_CW-1:0]     cfg_wr_timeout,          // Per port write timeout
	input  wire [`SPCC_PORTS-1:0]              use_term_string,         // String termination wanted
	input  wire [`SPCC_PORTS-1:0]              use_packet_len,          // Packet termination wanted
	input  wire [`SPCC_PORTS-1:0]              rx_char_valid,           // Character received, pulse
	input  wire [`SPCC_PORTS-1:0]              rx_buf_full,             // No room, char discarded
	input  wire [`SPCC_PORTS-1:0]              overrun_clear,           // Clear sticky overrun, pulse
	input  wire                                read_block_req,          // Build a read block, pulse
	output reg  [`SPCC_PORTS*`SPCC_CW-1:0]     eff_term_type,           // Type in use
	output reg  [`SPCC_PORTS*`SPCC_BW-1:0]     eff_baud,                // Baud in use
	output reg  [`SPCC_PORTS*`SPCC_CW-1:0]     eff_parity,              // Parity in use
	output reg  [`SPCC_PORTS*`SPCC_CW-1:0]     eff_data_bits,           // Data bits in use
	output reg  [`SPCC_PORTS*`SPCC_CW-1:0]     eff_stop_bits,           // Stop bits in use
	output reg  [`SPCC_PORTS*`SPCC_CW-1:0]     eff_handshake,           // Handshake in use
	output reg  [`SPCC_PORTS*`SPCC_CW-1:0]     eff_wr_timeout,          // Write timeout in use
	output reg  [`SPCC_PORTS-1:0]              en_term_string,          // String termination on
	output reg  [`SPCC_PORTS-1:0]              en_packet_len,           // Packet termination on
	output reg  [`SPCC_PORTS-1:0]              en_msg_timeout,          // Timeout termination on
	output reg  [`SPCC_PORTS-1:0]              en_gap,                  // Gap termination on
	output reg  [`SPCC_PORTS*`SPCC_CW-1:0]     port_config_fault_flags, // Live error words
	output reg  [`SPCC_PORTS-1:0]              receive_overrun_flag,    // Sticky overrun
	output reg                                 blk_valid,               // Read block status ready
	output reg  [`SPCC_PORTS*`SPCC_CW-1:0]     blk_fault_flags          // Error words in block
);

	// Combinational results of the per-port checkers
	wire [`SPCC_PORTS*`SPCC_CW-1:0]     chk_term_type;
	wire [`SPCC_PORTS*`SPCC_BW-1:0]     chk_baud;
	wire [`SPCC_PORTS*`SPCC_CW-1:0]     chk_parity;
	wire [`SPCC_PORTS*`SPCC_CW-1:0]     chk_data_bits;
	wire [`SPCC_PORTS*`SPCC_CW-1:0]     chk_stop_bits;
	wire [`SPCC_PORTS*`SPCC_CW-1:0]     chk_handshake;
	wire [`SPCC_PORTS*`SPCC_CW-1:0]     chk_wr_timeout;
	wire [`SPCC_PORTS-1:0]              chk_term_string;
	wire [`SPCC_PORTS-1:0]              chk_packet_len;
	wire [`SPCC_PORTS-1:0]              chk_msg_timeout;
	wire [`SPCC_PORTS-1:0]              chk_gap;
	wire [`SPCC_PORTS*(`SPCC_CFG_MSB+1)-1:0] chk_fault;
	wire [`SPCC_PORTS*`SPCC_CW-1:0]     next_fault_flags;
	wire [`SPCC_PORTS-1:0]              next_overrun;

	genvar gi;

	generate
		for (gi = 0; gi < `SPCC_PORTS; gi = gi + 1) begin : g_port

			// Validate this port's settings
			spcc_port_check u_check (
				.cfg_term_type   (cfg_term_type[gi*`SPCC_CW +: `SPCC_CW]),
				.cfg_baud        (cfg_baud[gi*`SPCC_BW +: `SPCC_BW]),
				.cfg_parity      (cfg_parity[gi*`SPCC_CW +: `SPCC_CW]),
				.cfg_data_bits   (cfg_data_bits[gi*`SPCC_CW +: `SPCC_CW]),
				.cfg_stop_bits   (cfg_stop_bits[gi*`SPCC_CW +: `SPCC_CW]),
				.cfg_handshake   (cfg_handshake[gi*`SPCC_CW +: `SPCC_CW]),
				.cfg_term_count  (cfg_term_count[gi*`SPCC_CW +: `SPCC_CW]),
				.cfg_packet_len  (cfg_packet_len[gi*`SPCC_CW +: `SPCC_CW]),
				.cfg_rx_timeout  (cfg_rx_timeout[gi*`SPCC_CW +: `SPCC_CW]),
				.cfg_gap         (cfg_gap[gi*`SPCC_CW +: `SPCC_CW]),
				.cfg_wr_timeout  (cfg_wr_timeout[gi*`SPCC_CW +: `SPCC_CW]),
				.use_term_string (use_term_string[gi]),
				.use_packet_len  (use_packet_len[gi]),
				.eff_term_type   (chk_term_type[gi*`SPCC_CW +: `SPCC_CW]),
				.eff_baud        (chk_baud[gi*`SPCC_BW +: `SPCC_BW]),
				.eff_parity      (chk_parity[gi*`SPCC_CW +: `SPCC_CW]),
				.eff_data_bits   (chk_data_bits[gi*`SPCC_CW +: `SPCC_CW]),
				.eff_stop_bits   (chk_stop_bits[gi*`SPCC_CW +: `SPCC_CW]),
				.eff_handshake   (chk_handshake[gi*`SPCC_CW +: `SPCC_CW]),
				.eff_wr_timeout  (chk_wr_timeout[gi*`SPCC_CW +: `SPCC_CW]),
				.en_term_string  (chk_term_string[gi]),
				.en_packet_len   (chk_packet_len[gi]),
				.en_msg_timeout  (chk_msg_timeout[gi]),
				.en_gap          (chk_gap[gi]),
				.cfg_fault       (chk_fault[gi*(`SPCC_CFG_MSB+1) +: (`SPCC_CFG_MSB+1)])
			);

			// Sticky overrun, a new discard wins over a clear
			assign next_overrun[gi] = (rx_char_valid[gi] & rx_buf_full[gi]) |
				(receive_overrun_flag[gi] & ~overrun_clear[gi]);

			// Assemble the error word, unassigned bits held low
			assign next_fault_flags[gi*`SPCC_CW +: `SPCC_CW] = {
				next_overrun[gi],
				4'h0,
				chk_fault[gi*(`SPCC_CFG_MSB+1) +: (`SPCC_CFG_MSB+1)]
			};
		end
	endgenerate

	// Register the settings in use
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			eff_term_type  <= {`SPCC_PORTS{`SPCC_TYPE_DEF}};
			eff_baud       <= {`SPCC_PORTS{`SPCC_BAUD_DEF}};
			eff_parity     <= {`SPCC_PORTS{`SPCC_PARITY_DEF}};
			eff_data_bits  <= {`SPCC_PORTS{`SPCC_DATA_DEF}};
			eff_stop_bits  <= {`SPCC_PORTS{`SPCC_STOP_ONE}};
			eff_handshake  <= {`SPCC_PORTS{`SPCC_HSHAKE_DEF}};
			eff_wr_timeout <= {`SPCC_PORTS{`SPCC_WTMO_DEF}};
		end else begin
			eff_term_type  <= chk_term_type;
			eff_baud       <= chk_baud;
			eff_parity     <= chk_parity;
			eff_data_bits  <= chk_data_bits;
			eff_stop_bits  <= chk_stop_bits;
			eff_handshake  <= chk_handshake;
			eff_wr_timeout <= chk_wr_timeout;
		end
	end

	// Register the termination enables
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			en_term_string <= {`SPCC_PORTS{1'b0}};
			en_packet_len  <= {`SPCC_PORTS{1'b0}};
			en_msg_timeout <= {`SPCC_PORTS{1'b0}};
			en_gap         <= {`SPCC_PORTS{1'b0}};
		end else begin
			en_term_string <= chk_term_string;
			en_packet_len  <= chk_packet_len;
			en_msg_timeout <= chk_msg_timeout;
			en_gap         <= chk_gap;
		end
	end

	// Live error words and sticky overrun
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			port_config_fault_flags <= {`SPCC_PORTS{`SPCC_ZERO16}};
			receive_overrun_flag    <= {`SPCC_PORTS{1'b0}};
		end else begin
			port_config_fault_flags <= next_fault_flags;
			receive_overrun_flag    <= next_overrun;
		end
	end

	// Snapshot of the error words for each read block
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			blk_valid       <= 1'b0;
			blk_fault_flags <= {`SPCC_PORTS{`SPCC_ZERO16}};
		end else begin
			blk_valid <= read_block_req;
			if (read_block_req) begin
				blk_fault_flags <= port_config_fault_flags;
			end
		end
	end

endmodule

// ===== logic/spcc_regs.vh
// Constants for the serial port configuration checker
// Contract
// - Termination type above 15 flags bit 0 and falls back to stream type 0.
// - Unsupported baud rate flags bit 1 and the port runs at 9600.
// - Parity codes 0 to 4 pass; others flag bit 2, use none.
// - Data bits 5 to 8 pass; others flag bit 3, use 8.
// - Stop bits 1 or 2 pass; others flag bit 4, use 1.
// - Handshake codes 0 to 3 pass; others flag bit 5, use 0.
// - With string end wanted, count outside 1 to 12 flags bit 6 and disables string end.
// - With packet end wanted, length outside 1 to 4096 flags bit 7, disables packet end.
// - Zero message timeout flags bit 8 and disables timeout end.
// - Zero character gap flags bit 9 and disables gap end.
// - Zero write timeout flags bit 10 and substitutes 5000 ms.
// - Discarded receive data sets sticky overrun bit 15.
// - Every read block carries each port's error word.
`ifndef SPCC_REGS_VH
`define SPCC_REGS_VH

`define SPCC_PORTS        2
`define SPCC_CW           16
`define SPCC_BW           32

`define SPCC_BIT_TYPE     0
`define SPCC_BIT_BAUD     1
`define SPCC_BIT_PARITY   2
`define SPCC_BIT_DATA     3
`define SPCC_BIT_STOP     4
`define SPCC_BIT_HSHAKE   5
`define SPCC_BIT_TCOUNT   6
`define SPCC_BIT_PLEN     7
`define SPCC_BIT_RTMO     8
`define SPCC_BIT_GAP      9
`define SPCC_BIT_WTMO     10
`define SPCC_BIT_OVR      15
`define SPCC_CFG_MSB      10

`define SPCC_TYPE_MAX     16'h000f
`define SPCC_TYPE_DEF     16'h0000
`define SPCC_BAUD_DEF     32'h00002580
`define SPCC_PARITY_MAX   16'h0004
`define SPCC_PARITY_DEF   16'h0000
`define SPCC_DATA_MIN     16'h0005
`define SPCC_DATA_MAX     16'h0008
`define SPCC_DATA_DEF     16'h0008
`define SPCC_STOP_ONE     16'h0001
`define SPCC_STOP_TWO     16'h0002
`define SPCC_HSHAKE_MAX   16'h0003
`define SPCC_HSHAKE_DEF   16'h0000
`define SPCC_TCOUNT_MIN   16'h0001
`define SPCC_TCOUNT_MAX   16'h000c
`define SPCC_PLEN_MIN     16'h0001
`define SPCC_PLEN_MAX     16'h1000
`define SPCC_WTMO_DEF     16'h1388
`define SPCC_ZERO16       16'h0000
`define SPCC_ZERO32       32'h00000000

// Supported baud rates, bits per second
`define SPCC_BAUD_0       32'h0000006e
`define SPCC_BAUD_1       32'h00000096
`define SPCC_BAUD_2       32'h0000012c
`define SPCC_BAUD_3       32'h00000258
`define SPCC_BAUD_4       32'h000004b0
`define SPCC_BAUD_5       32'h00000960
`define SPCC_BAUD_6       32'h000012c0
`define SPCC_BAUD_7       32'h00002580
`define SPCC_BAUD_8       32'h00004b00
`define SPCC_BAUD_9       32'h00009600
`define SPCC_BAUD_10      32'h0000e100
`define SPCC_BAUD_11      32'h0001c200

`endif

// ===== logic/spcc_port_check.v
// Combinational validation of one serial port's configuration
`timescale 1ns/100ps
`include "spcc_regs.vh"

module spcc_port_check (
	input  wire [`SPCC_CW-1:0] cfg_term_type,   // Termination type
	input  wire [`SPCC_BW-1:0] cfg_baud,        // Baud rate, bit/s
	input  wire [`SPCC_CW-1:0] cfg_parity,      // Parity code
	input  wire [`SPCC_CW-1:0] cfg_data_bits,   // Character length
	input  wire [`SPCC_CW-1:0] cfg_stop_bits,   // Stop bit count
	input  wire [`SPCC_CW-1:0] cfg_handshake,   // Handshake code
	input  wire [`SPCC_CW-1:0] cfg_term_count,  // Termination string length
	input  wire [`SPCC_CW-1:0] cfg_packet_len,  // Packet length
	input  wire [`SPCC_CW-1:0] cfg_rx_timeout,  // Message timeout
	input  wire [`SPCC_CW-1:0] cfg_gap,         // Inter-character gap
	input  wire [`SPCC_CW-1:0] cfg_wr_timeout,  // Write timeout, ms
	input  wire                use_term_string, // String termination wanted
	input  wire                use_packet_len,  // Packet termination wanted
	output reg  [`SPCC_CW-1:0] eff_term_type,   // Type in use
	output reg  [`SPCC_BW-1:0] eff_baud,        // Baud in use
	output reg  [`SPCC_CW-1:0] eff_parity,      // Parity in use
	output reg  [`SPCC_CW-1:0] eff_data_bits,   // Data bits in use
	output reg  [`SPCC_CW-1:0] eff_stop_bits,   // Stop bits in use
	output reg  [`SPCC_CW-1:0] eff_handshake,   // Handshake in use
	output reg  [`SPCC_CW-1:0] eff_wr_timeout,  // Write timeout in use
	output reg                 en_term_string,  // String termination on
	output reg                 en_packet_len,   // Packet termination on
	output reg                 en_msg_timeout,  // Timeout termination on
	output reg                 en_gap,          // Gap termination on
	output reg  [`SPCC_CFG_MSB:0] cfg_fault     // Configuration fault bits
);

	reg baud_ok;
	reg char_length_fault;
	reg trailer_bits_fault;
	reg fixed_length_fault;

	// Supported baud rate lookup
	always @* begin
		case (cfg_baud)
			`SPCC_BAUD_0, `SPCC_BAUD_1, `SPCC_BAUD_2, `SPCC_BAUD_3,
			`SPCC_BAUD_4, `SPCC_BAUD_5, `SPCC_BAUD_6, `SPCC_BAUD_7,
			`SPCC_BAUD_8, `SPCC_BAUD_9, `SPCC_BAUD_10, `SPCC_BAUD_11: baud_ok = 1'b1;
			default: baud_ok = 1'b0;
		endcase
	end

	// Range checks and safe substitutes
	always @* begin
		cfg_fault = {(`SPCC_CFG_MSB+1){1'b0}};
		cfg_fault[`SPCC_BIT_TYPE] = (cfg_term_type > `SPCC_TYPE_MAX);
		eff_term_type = cfg_fault[`SPCC_BIT_TYPE] ? `SPCC_TYPE_DEF : cfg_term_type;
		cfg_fault[`SPCC_BIT_BAUD] = ~baud_ok;
		eff_baud = baud_ok ? cfg_baud : `SPCC_BAUD_DEF;
		cfg_fault[`SPCC_BIT_PARITY] = (cfg_parity > `SPCC_PARITY_MAX);
		eff_parity = cfg_fault[`SPCC_BIT_PARITY] ? `SPCC_PARITY_DEF : cfg_parity;
		char_length_fault = (cfg_data_bits < `SPCC_DATA_MIN) || (cfg_data_bits > `SPCC_DATA_MAX);
		cfg_fault[`SPCC_BIT_DATA] = char_length_fault;
		eff_data_bits = char_length_fault ? `SPCC_DATA_DEF : cfg_data_bits;
		trailer_bits_fault = (cfg_stop_bits != `SPCC_STOP_ONE) && (cfg_stop_bits != `SPCC_STOP_TWO);
		cfg_fault[`SPCC_BIT_STOP] = trailer_bits_fault;
		eff_stop_bits = trailer_bits_fault ? `SPCC_STOP_ONE : cfg_stop_bits;
		cfg_fault[`SPCC_BIT_HSHAKE] = (cfg_handshake > `SPCC_HSHAKE_MAX);
		eff_handshake = cfg_fault[`SPCC_BIT_HSHAKE] ? `SPCC_HSHAKE_DEF : cfg_handshake;
		cfg_fault[`SPCC_BIT_TCOUNT] = use_term_string &&
			((cfg_term_count < `SPCC_TCOUNT_MIN) || (cfg_term_count > `SPCC_TCOUNT_MAX));
		en_term_string = use_term_string && ~cfg_fault[`SPCC_BIT_TCOUNT];
		fixed_length_fault = use_packet_len &&
			((cfg_packet_len < `SPCC_PLEN_MIN) || (cfg_packet_len > `SPCC_PLEN_MAX));
		cfg_fault[`SPCC_BIT_PLEN] = fixed_length_fault;
		en_packet_len = use_packet_len && ~fixed_length_fault;
		cfg_fault[`SPCC_BIT_RTMO] = (cfg_rx_timeout == `SPCC_ZERO16);
		en_msg_timeout = ~cfg_fault[`SPCC_BIT_RTMO];
		cfg_fault[`SPCC_BIT_GAP] = (cfg_gap == `SPCC_ZERO16);
		en_gap = ~cfg_fault[`SPCC_BIT_GAP];
		cfg_fault[`SPCC_BIT_WTMO] = (cfg_wr_timeout == `SPCC_ZERO16);
		eff_wr_timeout = cfg_fault[`SPCC_BIT_WTMO] ? `SPCC_WTMO_DEF : cfg_wr_timeout;
	end

endmodule

// ===== verification/spcc_asserts.sv
// Property checks on the configuration checker top ports
`timescale 1ns/100ps
module spcc_asserts (
	input wire        core_clk, // Clock
	input wire        rst, // Reset
	input wire [31:0] cfg_term_type, // Types
	input wire [31:0] cfg_wr_timeout, // Write timeouts
	input wire [1:0]  rx_char_valid, // Char strobes
	input wire [1:0]  rx_buf_full, // No room
	input wire [1:0]  overrun_clear, // Clears
	input wire        read_block_req, // Block request
	input wire [31:0] eff_term_type, // Types used
	input wire [31:0] eff_wr_timeout, // Timeouts used
	input wire [31:0] port_config_fault_flags, // Error words
	input wire [1:0]  receive_overrun_flag, // Overruns
	input wire        blk_valid, // Block ready
	input wire [31:0] blk_fault_flags // Block words
);
	// Port 1 word and discard strobe
	wire [15:0] w0;
	wire        lost0;
	assign w0 = port_config_fault_flags[15:0];
	assign lost0 = rx_char_valid[0] & rx_buf_full[0];
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	type_fault_a: assert property (cfg_term_type[15:0] > 16'h000f |=>
		w0[0] && eff_term_type[15:0] == 16'h0000) else $error("type fallback");
	wr_timeout_a: assert property (cfg_wr_timeout[15:0] == 16'h0000 |=>
		w0[10] && eff_wr_timeout[15:0] == 16'h1388) else $error("write timeout fallback");
	reserved_zero_a: assert property (w0[14:11] == 4'h0 &&
		port_config_fault_flags[30:27] == 4'h0) else $error("reserved bits set");
	overrun_set_a: assert property (lost0 |=>
		w0[15] && receive_overrun_flag[0]) else $error("overrun not set");
	overrun_hold_a: assert property (receive_overrun_flag[0] && !overrun_clear[0] |=>
		receive_overrun_flag[0] && w0[15]) else $error("overrun lost");
	overrun_clear_a: assert property (overrun_clear[0] && !lost0 |=>
		!receive_overrun_flag[0] && !w0[15]) else $error("overrun kept");
	block_snap_a: assert property (read_block_req |=>
		blk_valid && blk_fault_flags == $past(port_config_fault_flags)) else $error("block words wrong");
	block_pulse_a: assert property (!read_block_req |=>
		!blk_valid) else $error("block without request");
	cover property (lost0 ##1 receive_overrun_flag[0]);
	cover property (read_block_req ##1 blk_valid);
	cover property (cfg_wr_timeout[15:0] == 16'h0000 ##1 w0[10]);
endmodule

// ===== verification/spcc_host_model.sv
// Host controller model that asks for status read blocks
`timescale 1ns/100ps
module spcc_host_model (
	input  wire        core_clk, // Clock
	input  wire        blk_valid, // Block ready
	input  wire [31:0] blk_fault_flags, // Block words
	output reg         read_block_req // Block request
);
	initial read_block_req = 1'b0;
	// One request pulse, then take the words once the block is ready
	task fetch(output [31:0] words, output ok);
		integer n;
		begin
			ok = 1'b0;
			words = 32'h0;
			@(posedge core_clk) read_block_req <= 1'b1;
			@(posedge core_clk) read_block_req <= 1'b0;
			for (n = 0; n < 4 && ok !== 1'b1; n = n + 1) begin
				#1;
				if (blk_valid === 1'b1) {ok, words} = {1'b1, blk_fault_flags};
				else @(posedge core_clk);
			end
		end
	endtask
endmodule

// ===== verification/spcc_top_test.sv
// Self-checking testbench for the configuration checker
`timescale 1ns/100ps
module spcc_top_test;
	reg          core_clk; // 25 MHz clock
	reg          rst; // Reset
	reg  [191:0] c; // Port 1 fields
	reg  [1:0]   use_ts, use_pl, rx_v, rx_f, clr; // Controls
	wire         req, blk_v; // Block handshake
	wire [31:0]  flags, blk_w; // Error words
	wire [1:0]   ovr; // Overruns
	integer      fails, samples_checked; // Counters
	wire [31:0]  e_ty, e_pa, e_db, e_sb, e_hs, e_wt; // Values in use
	wire [63:0]  e_bd; // Baud in use
	wire [7:0]   e_en; // Enables, string, packet, timeout, gap
	// Valid values at range edges, baud 115200 on top
	localparam [191:0] good_cfg = {32'h0001c200, 16'h0001, 16'h0001, 16'h0001, 16'h1000, 16'h0001,
		16'h0000, 16'h0001, 16'h0005, 16'h0004, 16'h000f};
	spcc_top spcc_top_inst (.core_clk(core_clk), .rst(rst), .cfg_term_type({16'h0001, c[15:0]}),
		.cfg_parity({16'h0002, c[31:16]}), .cfg_data_bits({16'h0007, c[47:32]}), .cfg_stop_bits({16'h0002, c[63:48]}),
		.cfg_handshake({16'h0003, c[79:64]}), .cfg_term_count({16'h000c, c[95:80]}),
		.cfg_packet_len({16'h1000, c[111:96]}), .cfg_rx_timeout({16'h000a, c[127:112]}),
		.cfg_gap({16'h0005, c[143:128]}), .cfg_wr_timeout({16'h0064, c[159:144]}), .cfg_baud({32'h00004b00, c[191:160]}),
		.use_term_string(use_ts), .use_packet_len(use_pl), .rx_char_valid(rx_v), .rx_buf_full(rx_f),
		.overrun_clear(clr), .read_block_req(req), .eff_term_type(e_ty), .eff_baud(e_bd), .eff_parity(e_pa),
		.eff_data_bits(e_db), .eff_stop_bits(e_sb), .eff_handshake(e_hs), .eff_wr_timeout(e_wt),
		.en_term_string(e_en[1:0]), .en_packet_len(e_en[3:2]), .en_msg_timeout(e_en[5:4]), .en_gap(e_en[7:6]),
		.port_config_fault_flags(flags), .receive_overrun_flag(ovr), .blk_valid(blk_v), .blk_fault_flags(blk_w));
	spcc_host_model spcc_host_model_inst (.core_clk(core_clk), .blk_valid(blk_v), .blk_fault_flags(blk_w),
		.read_block_req(req));
	always #20 core_clk = ~core_clk;
	// Compare one 16-bit result
	task check16(input [8*16-1:0] what, input [15:0] exp, input [15:0] seen);
		begin
			samples_checked = samples_checked + 1;
			if (seen !== exp) begin
				fails = fails + 1;
				$display("MISMATCH %0s expected %h seen %h", what, exp, seen);
			end
		end
	endtask
	// Counts and verdict
	task complete_run;
		begin
			$display("compares %0d mismatches %0d", samples_checked, fails);
			if (fails == 0 && samples_checked > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask
	// Valid settings with one slot replaced, or both length slots cleared when f is 12 or more, judged live, in a block and in use
	task try_cfg(input [3:0] f, input [15:0] v, input [15:0] exp, input [15:0] sub);
		reg [191:0] t;
		reg [31:0]  w;
		reg         ok;
		reg [15:0]  u;
		begin
			t = good_cfg;
			if (f < 4'hc) t[f*16 +: 16] = v;
			else t[111:80] = 32'h0;
			@(posedge core_clk) c <= t;
			{use_ts, use_pl} <= (f < 4'hc) ? 4'hf : 4'ha;
			spcc_host_model_inst.fetch(w, ok);
			if (ok !== 1'b1) begin
				fails = fails + 1;
				$display("MISMATCH block_ready expected 1 seen %b", ok);
				complete_run;
			end
			check16("live_word", exp, flags[15:0]);
			check16("block_word_1", exp, w[15:0]);
			check16("block_word_2", 16'h0000, w[31:16]);
			case (f)
				4'h0: u = e_ty[15:0];
				4'h1: u = e_pa[15:0];
				4'h2: u = e_db[15:0];
				4'h3: u = e_sb[15:0];
				4'h4: u = e_hs[15:0];
				4'h5: u = {15'h0, e_en[0]};
				4'h6: u = {15'h0, e_en[2]};
				4'h7: u = {15'h0, e_en[4]};
				4'h8: u = {15'h0, e_en[6]};
				4'h9: u = e_wt[15:0];
				4'ha, 4'hb: u = e_bd[15:0];
				default: u = {12'h0, e_en[6], e_en[4], e_en[2], e_en[0]};
			endcase
			check16("value_used", sub, u);
		end
	endtask
	// Fault bits 0 to 10 in turn on port 1
	task scen_faults;
		begin
			try_cfg(4'hc, 16'h0000, 16'h0000, 16'h000c);
			try_cfg(4'h0, 16'h0010, 16'h0001, 16'h0000);
			try_cfg(4'ha, 16'h04d2, 16'h0002, 16'h2580);
			try_cfg(4'hb, 16'h0000, 16'h0002, 16'h2580);
			try_cfg(4'h1, 16'h0005, 16'h0004, 16'h0000);
			try_cfg(4'h2, 16'h0004, 16'h0008, 16'h0008);
			try_cfg(4'h2, 16'h0009, 16'h0008, 16'h0008);
			try_cfg(4'h3, 16'h0003, 16'h0010, 16'h0001);
			try_cfg(4'h4, 16'h0004, 16'h0020, 16'h0000);
			try_cfg(4'h5, 16'h000d, 16'h0040, 16'h0000);
			try_cfg(4'h6, 16'h1001, 16'h0080, 16'h0000);
			try_cfg(4'h7, 16'h0000, 16'h0100, 16'h0000);
			try_cfg(4'h8, 16'h0000, 16'h0200, 16'h0000);
			try_cfg(4'h9, 16'h0000, 16'h0400, 16'h1388);
			try_cfg(4'h0, 16'h000e, 16'h0000, 16'h000e);
			try_cfg(4'h1, 16'h0003, 16'h0000, 16'h0003);
			try_cfg(4'h2, 16'h0006, 16'h0000, 16'h0006);
			try_cfg(4'h3, 16'h0002, 16'h0000, 16'h0002);
			try_cfg(4'h4, 16'h0002, 16'h0000, 16'h0002);
			try_cfg(4'h5, 16'h000c, 16'h0000, 16'h0001);
			try_cfg(4'h6, 16'h0001, 16'h0000, 16'h0001);
			try_cfg(4'h9, 16'h0064, 16'h0000, 16'h0064);
			$display("scen_faults done");
		end
	endtask
	// Discard sets sticky bit, clear beside a discard loses
	task scen_overrun;
		begin
			@(posedge core_clk) rx_v <= 2'b01;
			@(posedge core_clk) rx_f <= 2'b01;
			#1 check16("overrun_idle", 16'h0000, {14'h0, ovr});
			@(posedge core_clk) rx_v <= 2'b00;
			#1 check16("overrun_set", 16'h0003, {14'h0, flags[15], ovr[0]});
			@(posedge core_clk) {rx_v, clr} <= 4'h5;
			@(posedge core_clk) {rx_v, clr} <= 4'h0;
			#1 check16("set_wins", 16'h0003, {14'h0, flags[15], ovr[0]});
			@(posedge core_clk) clr <= 2'b01;
			@(posedge core_clk) clr <= 2'b00;
			#1 check16("overrun_clear", 16'h0000, {13'h0, flags[31], flags[15], ovr[0]});
			@(posedge core_clk) {rx_v, rx_f} <= 4'ha;
			@(posedge core_clk) rx_v <= 2'b00;
			#1 check16("overrun_set_2", 16'h000c, {12'h0, flags[31], ovr[1], flags[15], ovr[0]});
			@(posedge core_clk) clr <= 2'b10;
			@(posedge core_clk) clr <= 2'b00;
			#1 check16("overrun_clr_2", 16'h0000, {12'h0, flags[31], ovr[1], flags[15], ovr[0]});
			$display("scen_overrun done");
		end
	endtask
	// Valid settings pass through unchanged on both ports
	task scen_pass;
		begin
			@(posedge core_clk) c <= good_cfg;
			{use_ts, use_pl} <= 4'hf;
			repeat (2) @(posedge core_clk);
			#1 check16("good_word", 16'h0000, flags[15:0]);
			check16("type_1", 16'h000f, e_ty[15:0]);
			check16("type_2", 16'h0001, e_ty[31:16]);
			check16("parity_2", 16'h0002, e_pa[31:16]);
			check16("data_2", 16'h0007, e_db[31:16]);
			check16("stop_2", 16'h0002, e_sb[31:16]);
			check16("handshake_2", 16'h0003, e_hs[31:16]);
			check16("wr_timeout_2", 16'h0064, e_wt[31:16]);
			check16("baud_1_lo", 16'hc200, e_bd[15:0]);
			check16("baud_1_hi", 16'h0001, e_bd[31:16]);
			check16("baud_2_lo", 16'h4b00, e_bd[47:32]);
			check16("baud_2_hi", 16'h0000, e_bd[63:48]);
			check16("enables", 16'h00ff, {8'h0, e_en});
			$display("scen_pass done");
		end
	endtask
	// Reset, scenarios, verdict
	initial begin
		core_clk = 1'b0;
		rst = 1'b1;
		c = good_cfg;
		{use_ts, use_pl, rx_v, rx_f, clr} = 10'h3c0;
		fails = 0;
		samples_checked = 0;
		repeat (3) @(posedge core_clk);
		@(posedge core_clk) rst <= 1'b0;
		scen_faults;
		scen_overrun;
		scen_pass;
		complete_run;
	end
endmodule
bind spcc_top spcc_asserts spcc_asserts_inst (.core_clk(core_clk), .rst(rst), .cfg_term_type(cfg_term_type),
	.cfg_wr_timeout(cfg_wr_timeout), .rx_char_valid(rx_char_valid), .rx_buf_full(rx_buf_full),
	.overrun_clear(overrun_clear), .read_block_req(read_block_req), .eff_term_type(eff_term_type),
	.eff_wr_timeout(eff_wr_timeout), .port_config_fault_flags(port_config_fault_flags),
	.receive_overrun_flag(receive_overrun_flag), .blk_valid(blk_valid), .blk_fault_flags(blk_fault_flags));
